// [verilog/wai_pkg.sv]
package wai_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int AW = 20;
  localparam int DW = 16;
  localparam int NREG = 16;

  // ----------------------------------------------------------------
  // register file indices and register port map
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_PC = 4'h0;
  localparam logic [3:0] IDX_SP = 4'h1;
  localparam logic [3:0] IDX_SR = 4'h2;
  localparam logic [4:0] PORT_STATUS = 5'h10;
  localparam logic [19:0] RF_RESET = 20'h00000;

  // status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 8;

  // fixed arithmetic constants
  localparam logic [19:0] STEP_WORD = 20'h00002;
  localparam logic [19:0] STEP_PAIR = 20'h00004;

  // ----------------------------------------------------------------
  // operations and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD_ADDRESS_WORD,
    OP_COMPARE_ADDRESS_WORD,
    OP_CLEAR_ADDRESS_REGISTER,
    OP_DOUBLE_DECREMENT_ADDRESS,
    OP_DOUBLE_INCREMENT_ADDRESS,
    OP_MOVE_ADDRESS_WORD,
    OP_FAR_BRANCH,
    OP_FAR_CALL,
    OP_FAR_RETURN
  } wai_op_t;

  typedef enum logic [2:0] {
    MD_REGISTER,
    MD_IMMEDIATE,
    MD_SYMBOLIC,
    MD_ABSOLUTE,
    MD_INDIRECT,
    MD_INDIRECT_INC,
    MD_INDEXED
  } wai_mode_t;

endpackage

// [verilog/wai_exec.sv]
`timescale 1ns/1ns
`default_nettype none

module wai_exec (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire wai_pkg::wai_op_t CMD_OP,
  input wire wai_pkg::wai_mode_t CMD_MODE,
  input wire logic [3:0] CMD_SRC,
  input wire logic [3:0] CMD_DST,
  input wire logic [19:0] CMD_IMM,
  output logic BUSY,
  output logic DONE,
  output logic ERR,
  output logic [19:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic MEM_WR,
  output logic MEM_RD,
  input wire logic [15:0] MEM_RDATA,
  input wire logic [4:0] REG_ADDR,
  input wire logic [19:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [19:0] REG_RDATA
);
  import wai_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // full 20-bit adder: {v, c, sum}
  function automatic logic [21:0] add20(input logic [19:0] a,
                                        input logic [19:0] b,
                                        input logic cin);
    logic [20:0] s;
    logic v;
    s = {1'b0, a} + {1'b0, b} + {20'h00000, cin};
    v = (a[19] == b[19]) && (s[19] != a[19]);
    return {v, s};
  endfunction

  function automatic logic [19:0] sext16(input logic [19:0] x);
    return {{4{x[15]}}, x[15:0]};
  endfunction

  // operand sits in two memory words; the sequencer and the bus share
  // this so both leave idle on the very same decision
  function automatic logic fetches(input wai_op_t op, input wai_mode_t md);
    logic jump;
    logic mem;
    jump = (op == OP_FAR_BRANCH) || (op == OP_FAR_CALL);
    mem = (md != MD_REGISTER) && (md != MD_IMMEDIATE);
    return (op == OP_FAR_RETURN) || (jump && mem);
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LO,
    ST_RD_HI,
    ST_RD_END,
    ST_PUSH_HI,
    ST_PUSH_LO
  } wai_state_t;

  wai_state_t st_q;
  logic [19:0] rf_q [NREG];
  logic [19:0] tgt_q;
  logic [15:0] lo_q;
  logic [3:0] ptr_q;
  logic inc_q;
  logic call_q;
  logic ret_q;
  logic err_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic accept;
  logic is_alu;
  logic is_jump;
  logic direct;
  logic alu_ok;
  logic [19:0] srcv;
  logic [19:0] dstv;
  logic [19:0] ea;
  logic [21:0] alu;
  logic [19:0] sr_upd;
  logic fetch;
  logic push_now;

  assign accept = CMD_VALID && (st_q == ST_IDLE);
  assign is_jump = (CMD_OP == OP_FAR_BRANCH) || (CMD_OP == OP_FAR_CALL);
  assign is_alu = !is_jump && (CMD_OP != OP_FAR_RETURN);
  assign direct = (CMD_MODE == MD_REGISTER) || (CMD_MODE == MD_IMMEDIATE);
  assign alu_ok = is_alu && direct;
  assign srcv = (CMD_MODE == MD_IMMEDIATE) ? CMD_IMM : rf_q[CMD_SRC];
  assign dstv = rf_q[CMD_DST];
  assign fetch = accept && fetches(CMD_OP, CMD_MODE);
  // direct call pushes at once; a memory call only once its
  // target is held, so the stack never sees a half-built target
  assign push_now = accept && !fetch && (CMD_OP == OP_FAR_CALL);

  // effective address of a two-word target in memory
  always_comb begin
    unique case (CMD_MODE)
      MD_SYMBOLIC: ea = rf_q[IDX_PC] + sext16(CMD_IMM);
      MD_ABSOLUTE: ea = CMD_IMM;
      MD_INDEXED: ea = rf_q[CMD_SRC] + sext16(CMD_IMM);
      default: ea = rf_q[CMD_SRC];
    endcase
    if (CMD_OP == OP_FAR_RETURN) begin
      ea = rf_q[IDX_SP];
    end
  end

  // one adder serves every arithmetic op; subtraction is ~subtrahend + 1 (src for compare, STEP_WORD for decrement)
  always_comb begin
    unique case (CMD_OP)
      OP_COMPARE_ADDRESS_WORD: alu = add20(dstv, ~srcv, 1'b1);
      OP_DOUBLE_DECREMENT_ADDRESS: alu = add20(dstv, ~STEP_WORD, 1'b1);
      OP_DOUBLE_INCREMENT_ADDRESS: alu = add20(dstv, STEP_WORD, 1'b0);
      default: alu = add20(srcv, dstv, 1'b0);
    endcase
  end

  // only N Z C V move; mode bits pass through
  always_comb begin
    sr_upd = rf_q[IDX_SR];
    sr_upd[SR_N] = alu[19];
    sr_upd[SR_Z] = (alu[19:0] == 20'h00000);
    sr_upd[SR_C] = alu[20];
    sr_upd[SR_V] = alu[21];
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // reads are pipelined: low strobe, high strobe, then two captures
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (fetch) begin
            st_q <= ST_RD_LO;
          end else if (push_now) begin
            st_q <= ST_PUSH_HI;
          end
        end
        ST_RD_LO: st_q <= ST_RD_HI;
        ST_RD_HI: st_q <= ST_RD_END;
        ST_RD_END: st_q <= call_q ? ST_PUSH_HI : ST_IDLE;
        ST_PUSH_HI: st_q <= ST_PUSH_LO;
        ST_PUSH_LO: st_q <= ST_IDLE;
        // two of the eight codes are unused; recover to idle
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // held command context for the multi-cycle ops
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tgt_q <= RF_RESET;
      lo_q <= 16'h0000;
      ptr_q <= 4'h0;
      inc_q <= 1'b0;
      call_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      if (accept) begin
        tgt_q <= srcv;
        ptr_q <= CMD_SRC;
        inc_q <= is_jump && (CMD_MODE == MD_INDIRECT_INC);
        call_q <= (CMD_OP == OP_FAR_CALL);
        ret_q <= (CMD_OP == OP_FAR_RETURN);
      end
      if (st_q == ST_RD_HI) begin
        lo_q <= MEM_RDATA;
      end
      // upper bits from the second word
      if (st_q == ST_RD_END) begin
        tgt_q <= {MEM_RDATA[3:0], lo_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // a command accepted in the same cycle as a port write wins
  // limitation: an add, decrement or increment naming the status register as destination
  // ends with the new flags there, as the flag write comes last
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NREG; i++) begin
        rf_q[i] <= RF_RESET;
      end
    end else begin
      if (REG_WR && st_q == ST_IDLE && !accept && !REG_ADDR[4]) begin
        rf_q[REG_ADDR[3:0]] <= REG_WDATA;
      end
      if (accept && alu_ok) begin
        unique case (CMD_OP)
          OP_COMPARE_ADDRESS_WORD: begin
            rf_q[IDX_SR] <= sr_upd;
          end
          OP_CLEAR_ADDRESS_REGISTER: begin
            rf_q[CMD_DST] <= RF_RESET;
          end
          OP_MOVE_ADDRESS_WORD: begin
            rf_q[CMD_DST] <= srcv;
          end
          default: begin
            rf_q[CMD_DST] <= alu[19:0];
            rf_q[IDX_SR] <= sr_upd;
          end
        endcase
      end
      if (accept && CMD_OP == OP_FAR_BRANCH && direct) begin
        rf_q[IDX_PC] <= srcv;
      end
      if (st_q == ST_RD_END) begin
        if (ret_q) begin
          rf_q[IDX_PC] <= {MEM_RDATA[3:0], lo_q};
          rf_q[IDX_SP] <= rf_q[IDX_SP] + STEP_PAIR;
        end else begin
          if (inc_q) begin
            rf_q[ptr_q] <= rf_q[ptr_q] + STEP_PAIR;
          end
          if (!call_q) begin
            rf_q[IDX_PC] <= {MEM_RDATA[3:0], lo_q};
          end
        end
      end
      if (st_q == ST_PUSH_LO) begin
        rf_q[IDX_SP] <= rf_q[IDX_SP] - STEP_PAIR;
        rf_q[IDX_PC] <= tgt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory bus
  // ----------------------------------------------------------------
  // strobes are one cycle; data return in the cycle after a read
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      MEM_ADDR <= RF_RESET;
      MEM_WDATA <= 16'h0000;
      MEM_WR <= 1'b0;
      MEM_RD <= 1'b0;
    end else begin
      MEM_WR <= 1'b0;
      MEM_RD <= 1'b0;
      if (fetch) begin
        MEM_RD <= 1'b1;
        MEM_ADDR <= ea;
      end else if (st_q == ST_RD_LO) begin
        MEM_RD <= 1'b1;
        MEM_ADDR <= MEM_ADDR + STEP_WORD;
      end else if (push_now || (st_q == ST_RD_END && call_q)) begin
        MEM_WR <= 1'b1;
        MEM_ADDR <= rf_q[IDX_SP] - STEP_WORD;
        MEM_WDATA <= {12'h000, rf_q[IDX_PC][19:16]};
      end else if (st_q == ST_PUSH_HI) begin
        MEM_WR <= 1'b1;
        MEM_ADDR <= rf_q[IDX_SP] - STEP_PAIR;
        MEM_WDATA <= rf_q[IDX_PC][15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake and status
  // ----------------------------------------------------------------
  // busy is registered so it lags accept by one edge; the host must
  // not present a second command in the cycle after an accept
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ERR <= 1'b0;
      err_q <= 1'b0;
    end else begin
      DONE <= 1'b0;
      ERR <= 1'b0;
      if (accept) begin
        // memory mode on an ALU op refused
        err_q <= is_alu && !direct;
        ERR <= is_alu && !direct;
      end
      if (accept && (is_alu || (CMD_OP == OP_FAR_BRANCH && direct))) begin
        DONE <= 1'b1;
      end else if (accept) begin
        BUSY <= 1'b1;
      end
      if ((st_q == ST_RD_END && !call_q) || st_q == ST_PUSH_LO) begin
        BUSY <= 1'b0;
        DONE <= 1'b1;
      end
    end
  end

  // register port read data: valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= RF_RESET;
    end else if (!REG_RD) begin
      REG_RDATA <= RF_RESET;
    end else if (!REG_ADDR[4]) begin
      REG_RDATA <= rf_q[REG_ADDR[3:0]];
    end else if (REG_ADDR == PORT_STATUS) begin
      // call bit drops once the call is over
      REG_RDATA <= {17'h00000, err_q, call_q && (st_q != ST_IDLE),
                    st_q != ST_IDLE};
    end else begin
      REG_RDATA <= RF_RESET;
    end
  end

endmodule

`default_nettype wire

// [sim/wai_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// word memory, read data stand only in the cycle after the strobe
module wai_mem_model (
  input wire logic clk,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:255];
  initial rdata = 16'h5a5a;
  // stack word store
  // outside a read the bus shows the inverse, so stale data never passes
  always @(posedge clk) begin
    if (wr) mem[addr[8:1]] <= wdata;
    rdata <= rd ? mem[addr[8:1]] : ~rdata;
  end
endmodule
`default_nettype wire

// [sim/wai_exec_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module wai_exec_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire wai_pkg::wai_op_t CMD_OP,
  input wire wai_pkg::wai_mode_t CMD_MODE,
  input wire logic [19:0] CMD_IMM,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic ERR,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic MEM_WR,
  input wire logic MEM_RD
);
  import wai_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // accept decode: idle is seen as busy low
  // ----------------------------------------------------------------
  logic acc, alu, dir, far_branch, cal;
  assign acc = CMD_VALID && !BUSY;
  assign alu = CMD_OP <= OP_MOVE_ADDRESS_WORD;
  assign dir = CMD_MODE inside {MD_REGISTER, MD_IMMEDIATE};
  assign far_branch = acc && CMD_OP == OP_FAR_BRANCH;
  assign cal = acc && CMD_OP == OP_FAR_CALL;
  property p_err_refuse;
    acc && alu && !dir |=> ERR && DONE;
  endproperty
  a_err_refuse: assert property (p_err_refuse)
    else $error("memory mode alu op not refused");
  property p_alu_one;
    acc && alu && dir |=> DONE && !ERR && !BUSY;
  endproperty
  a_alu_one: assert property (p_alu_one)
    else $error("alu op not done in one cycle");
  property p_bra_direct;
    far_branch && dir |=> DONE && !MEM_RD && !MEM_WR;
  endproperty
  a_bra_direct: assert property (p_bra_direct)
    else $error("direct branch touched memory");
  property p_abs_fetch;
    far_branch && CMD_MODE == MD_ABSOLUTE |=> MEM_RD && MEM_ADDR == $past(CMD_IMM)
      ##1 MEM_RD && MEM_ADDR == $past(CMD_IMM, 2) + 20'h00002 ##2 DONE;
  endproperty
  a_abs_fetch: assert property (p_abs_fetch)
    else $error("absolute target fetch wrong");
  property p_rd_pair;
    $rose(MEM_RD) |=> MEM_RD ##1 !MEM_RD;
  endproperty
  a_rd_pair: assert property (p_rd_pair)
    else $error("target not read as two words");
  property p_push_pair;
    $rose(MEM_WR) |-> MEM_WDATA[15:4] == 12'h000
      ##1 MEM_WR && MEM_ADDR == $past(MEM_ADDR) - 20'h00002;
  endproperty
  a_push_pair: assert property (p_push_pair)
    else $error("return push order wrong");
  property p_call_direct;
    cal && dir |=> MEM_WR ##1 MEM_WR ##1 DONE && !MEM_WR;
  endproperty
  a_call_direct: assert property (p_call_direct)
    else $error("direct call sequence wrong");
  property p_call_mem;
    cal && !dir |=> !MEM_WR [*3] ##1 MEM_WR [*2] ##1 DONE;
  endproperty
  a_call_mem: assert property (p_call_mem)
    else $error("target not held before push");
  property p_ret_fetch;
    acc && CMD_OP == OP_FAR_RETURN |=> MEM_RD ##1 MEM_RD ##2 DONE && !BUSY;
  endproperty
  a_ret_fetch: assert property (p_ret_fetch)
    else $error("return pop sequence wrong");
endmodule
bind wai_exec wai_exec_chk i_wai_exec_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_MODE(CMD_MODE),
  .CMD_IMM(CMD_IMM), .BUSY(BUSY), .DONE(DONE), .ERR(ERR),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR),
  .MEM_RD(MEM_RD));
`default_nettype wire

// [sim/wai_exec_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module wai_exec_tb_top;
  import wai_pkg::*;
  logic SYS_CLK, RST, CMD_VALID, REG_WR, REG_RD, BUSY, DONE, ERR;
  logic MEM_WR, MEM_RD, rd_d, v;
  wai_op_t CMD_OP;
  wai_mode_t CMD_MODE;
  logic [3:0] CMD_SRC, CMD_DST;
  logic [4:0] REG_ADDR;
  logic [15:0] MEM_WDATA, MEM_RDATA;
  logic [19:0] CMD_IMM, MEM_ADDR, REG_WDATA, REG_RDATA, t, s, d, b, e, f;
  logic [20:0] sum;
  logic [19:0] exp_q[$];
  logic [31:0] lf;
  int failures, n_compared;
  localparam logic [19:0] SR0 = 20'h00038;
  localparam logic [19:0] SRF = 20'h0013f;
  wai_exec i_wai_exec (.SYS_CLK(SYS_CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_MODE(CMD_MODE), .CMD_SRC(CMD_SRC),
    .CMD_DST(CMD_DST), .CMD_IMM(CMD_IMM), .BUSY(BUSY), .DONE(DONE),
    .ERR(ERR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR),
    .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));
  wai_mem_model i_wai_mem_model (.clk(SYS_CLK), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .wr(MEM_WR), .rd(MEM_RD), .rdata(MEM_RDATA));
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // ----------------------------------------------------------------
  // drivers and read-data watcher
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [19:0] x);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= x;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [19:0] x);
    exp_q.push_back(x);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
  endtask
  task automatic cmd(input wai_op_t o, input wai_mode_t m,
                     input logic [3:0] r, input logic [19:0] i);
    int k;
    int n;
    bit dir;
    dir = m inside {MD_REGISTER, MD_IMMEDIATE};
    // cycle of DONE counted from the accepting edge
    n = (o > OP_MOVE_ADDRESS_WORD) ? 4 : 1;
    if (o == OP_FAR_CALL) n = dir ? 3 : 6;
    if (o == OP_FAR_BRANCH && dir) n = 1;
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b1;
    CMD_OP <= o;
    CMD_MODE <= m;
    CMD_SRC <= r;
    CMD_IMM <= i;
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
    k = 0;
    do begin
      @(negedge SYS_CLK);
      k++;
    end while (DONE !== 1'b1 && k < 12);
    n_compared++;
    if (k != n) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, k, n);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // read data stand one cycle only, so look mid-cycle after the strobe
  always @(posedge SYS_CLK) rd_d <= REG_RD;
  always @(negedge SYS_CLK) begin
    if (rd_d === 1'b1) begin
      e = exp_q.pop_front();
      n_compared++;
      if (REG_RDATA !== e) begin
        failures++;
        $display("[ERR] %0t got %h exp %h", $time, REG_RDATA, e);
      end
    end
  end
  // whole run is near 1000 cycles; ten times that means a hang
  initial begin
    #200000;
    failures++;
    summarize();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {CMD_VALID, REG_WR, REG_RD} = '0;
    {CMD_SRC, CMD_DST, CMD_IMM, REG_ADDR, REG_WDATA} = '0;
    CMD_OP = OP_ADD_ADDRESS_WORD;
    CMD_MODE = MD_REGISTER;
    CMD_DST = 4'h5;
    failures = 0;
    n_compared = 0;
    lf = 32'hfd7d;
    RST = 1'b1;
    repeat (12) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(5'h3, RF_RESET);
    // add, compare, clear, decrement, increment with boundary operands
    for (int i = 0; i < 8; i++) begin
      for (int o = 0; o < 5; o++) begin
        lf = nxt(lf);
        s = lf[19:0];
        d = (i < 4) ? 20'(i) : (i == 4 ? 20'hffffe : lf[31:12]);
        b = o == 0 ? s : o == 1 ? ~s : o == 3 ? 20'hffffd : STEP_WORD;
        sum = {1'b0, d} + {1'b0, b} + 21'(o == 1 || o == 3);
        v = d[19] == b[19] && sum[19] != d[19];
        wr(5'h7, s);
        wr(5'h5, d);
        wr(5'h2, SRF);
        cmd(wai_op_t'(o), (i % 2) ? MD_IMMEDIATE : MD_REGISTER, 4'h7, s);
        f = o == 2 ? 20'h0 : o == 1 ? d : sum[19:0];
        rd(5'h5, f);
        f = SR0 | {11'h0, v, 5'h0, sum[19], sum[19:0] == 20'h0, sum[20]};
        rd(5'h2, o == 2 ? SRF : f);
        rd(5'h7, s);
      end
    end
    wr(5'h5, 20'h12345);
    cmd(OP_ADD_ADDRESS_WORD, MD_INDIRECT, 4'h7, 20'h0);
    rd(5'h5, 20'h12345);
    rd(5'h10, 20'h00004);
    // far branch then far call in all seven modes, call undone by return
    for (int op = 0; op < 2; op++) begin
      for (int m = 0; m < 7; m++) begin
        lf = nxt(lf);
        t = lf[19:0];
        i_wai_mem_model.mem[8'h20] = t[15:0];
        i_wai_mem_model.mem[8'h21] = {lf[31:20], t[19:16]};
        s = m == 0 ? t : (m == 6 ? 20'h00050 : 20'h00040);
        d = m == 1 ? t : m == 2 ? 20'h00020 : m == 3 ? 20'h00040 : 20'h0fff0;
        wr(5'h6, s);
        wr(5'h0, 20'h50020);
        wr(5'h1, 20'h00100);
        wr(5'h2, SRF);
        cmd(op ? OP_FAR_CALL : OP_FAR_BRANCH, wai_mode_t'(m), 4'h6, d);
        rd(5'h0, t);
        rd(5'h2, SRF);
        rd(5'h6, m == 5 ? s + STEP_PAIR : s);
        rd(5'h1, op ? 20'h000fc : 20'h00100);
        if (op) begin
          cmd(OP_FAR_RETURN, MD_REGISTER, 4'h6, 20'h0);
          rd(5'h0, 20'h50020);
          rd(5'h1, 20'h00100);
        end
      end
    end
    rd(5'h11, 20'h0);
    repeat (3) @(posedge SYS_CLK);
    summarize();
  end
endmodule
`default_nettype wire
